// >>> hdl/bit_manipulation_pkg.sv
package bit_manipulation_pkg;

    // Operation chosen by the decoder
    typedef enum logic [3:0] {
        op_none,
        op_ext_s,
        op_ext_u,
        op_insert,
        op_clear,
        op_set,
        op_reverse,
        op_rotate,
        op_ff1,
        op_fl1,
        op_clb,
        op_cnt
    } op_t;

    // Whole registered state of the unit
    typedef struct packed {
        logic        valid;
        logic        illegal;
        op_t         op;
        logic [4:0]  pos;
        logic [4:0]  width_m1;
        logic [31:0] result;
    } state_t;

endpackage : bit_manipulation_pkg

// >>> hdl/bit_manipulation_unit.sv
// What this block does
// - Signed extract, field bounded at 31, sign-extended
// - Unsigned extract, same field, zero-extended
// - Register extract: pos rs2[4:0], width rs2[9:5]
// - Insert low source bits, keep other destination
// - Clear bounded field, pass other bits
// - Set bounded field, pass other bits
// - Register insert/clear/set take fields from source two
// - Find first one; zero gives 32
// - Find last one; zero gives 32
// - Leading identical bits minus one; zero gives 0
// - Population count of first source
// - Rotate first source right by second source
// - Reverse groups of one, two or three
// - Group selector three behaves as zero
// - Shift left by position before reversing
// - Immediate field group decode on opcode 5B
// - Immediate clear, set, reverse decode
// - Register group decode by funct7 codes
// - Only active when extension is built in
`timescale 1ns/10ps
`include "bit_manipulation_unit_defs.svh"
module bit_manipulation_unit #(
    parameter bit CUSTOM_EXTENSION_ENABLE = 1'b1
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_valid,
    input  wire logic [31:0] i_instr,
    input  wire logic [31:0] i_first_source,
    input  wire logic [31:0] i_second_source,
    input  wire logic [31:0] i_dest_old,
    output logic             o_valid,
    output logic             o_illegal,
    output logic [31:0]      o_result
);
    import bit_manipulation_pkg::*;

    bm_decode_if dif ();                 // Decoder bundle
    state_t      state_q;                // Registered state
    state_t      state_d;                // Next state

    // Decoder sees the raw instruction
    assign dif.instr = i_instr;

    bm_decoder #(
        .CUSTOM_EXTENSION_ENABLE (CUSTOM_EXTENSION_ENABLE)
    ) u_dec (
        .d (dif)
    );

    // Mask of bits pos up to min(pos+w,31)
    function automatic logic [31:0] field_mask(input logic [4:0] pos, input logic [4:0] w);
        logic [5:0]  hi;
        logic [31:0] m;
        hi = 6'({1'b0, pos}) + 6'({1'b0, w});
        if (hi > `BMU_TOP_BIT)
        begin
            hi = `BMU_TOP_BIT;
        end
        m = 32'h0000_0000;
        for (int i = 0; i < 32; i++)
        begin
            m[i] = (6'(i) >= {1'b0, pos}) && (6'(i) <= hi);
        end
        return m;
    endfunction : field_mask

    // Grouped reversal of an already shifted word
    function automatic logic [31:0] reverse_groups(input logic [31:0] x, input logic [1:0] grp);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (grp)
            2'h1:
            begin
                for (int j = 0; j < 16; j++)
                begin
                    r[2*j +: 2] = x[31-2*j -: 2];
                end
            end
            2'h2:
            begin
                // Ten triples; the two low input bits fall away
                for (int j = 0; j < 10; j++)
                begin
                    r[3*j +: 3] = x[31-3*j -: 3];
                end
            end
            default:
            begin
                for (int j = 0; j < 32; j++)
                begin
                    r[j] = x[31-j];
                end
            end
        endcase
        return r;
    endfunction : reverse_groups

    // Index of lowest set bit, 32 if none
    function automatic logic [5:0] find_first(input logic [31:0] x);
        logic [5:0] r;
        r = `BMU_FIND_NONE;
        for (int i = 31; i >= 0; i--)
        begin
            if (x[i])
            begin
                r = 6'(i);
            end
        end
        return r;
    endfunction : find_first

    // Index of highest set bit, 32 if none
    function automatic logic [5:0] find_last(input logic [31:0] x);
        logic [5:0] r;
        r = `BMU_FIND_NONE;
        for (int i = 0; i < 32; i++)
        begin
            if (x[i])
            begin
                r = 6'(i);
            end
        end
        return r;
    endfunction : find_last

    // Run of bits equal to the top bit, minus one
    function automatic logic [5:0] leading_bits(input logic [31:0] x);
        logic [5:0] r;
        logic       run;
        r   = 6'h00;
        run = 1'b1;
        for (int i = 30; i >= 0; i--)
        begin
            run = run && (x[i] == x[31]);
            if (run)
            begin
                r = r + 6'h01;
            end
        end
        if (x == 32'h0000_0000)
        begin
            r = 6'h00;
        end
        return r;
    endfunction : leading_bits

    // Number of ones
    function automatic logic [5:0] ones_count(input logic [31:0] x);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < 32; i++)
        begin
            r = r + 6'({5'h00, x[i]});
        end
        return r;
    endfunction : ones_count

    // Next state: decode, resolve fields, compute result
    always_comb
    begin
        logic [4:0]  pos;
        logic [4:0]  wm1;
        logic [31:0] mask;
        logic [31:0] low;
        logic [31:0] shifted;
        logic [31:0] rev_in;
        logic [5:0]  hi;
        logic [63:0] dbl;
        // Register forms read position and width from the second source
        pos = dif.reg_form ? i_second_source[`BMU_RS_P_MSB:`BMU_RS_P_LSB] : dif.imm_pos;
        wm1 = dif.reg_form ? i_second_source[`BMU_RS_W_MSB:`BMU_RS_W_LSB] : dif.imm_w;
        hi  = 6'({1'b0, pos}) + 6'({1'b0, wm1});
        if (hi > `BMU_TOP_BIT)
        begin
            hi = `BMU_TOP_BIT;
        end
        mask    = field_mask(pos, wm1);
        low     = field_mask(5'h00, 5'(hi - 6'({1'b0, pos})));
        shifted = (i_first_source >> pos) & low;
        rev_in  = i_first_source << dif.imm_pos;
        dbl     = {i_first_source, i_first_source} >> i_second_source[4:0];
        state_d          = state_q;
        state_d.valid    = i_valid;
        state_d.illegal  = i_valid && dif.illegal;
        state_d.op       = dif.op;
        state_d.pos      = pos;
        state_d.width_m1 = wm1;
        // Result only changes on a valid request; a refused one gives zero
        if (i_valid)
        begin
            case (dif.op)
                op_ext_s:   state_d.result = shifted | (i_first_source[hi[4:0]] ? ~low : 32'h0000_0000);
                op_ext_u:   state_d.result = shifted;
                op_insert:  state_d.result = (i_dest_old & ~mask) | ((i_first_source << pos) & mask);
                op_clear:   state_d.result = i_first_source & ~mask;
                op_set:     state_d.result = i_first_source | mask;
                op_reverse: state_d.result = reverse_groups(rev_in, dif.group);
                op_rotate:  state_d.result = dbl[31:0];
                op_ff1:     state_d.result = {26'h0, find_first(i_first_source)};
                op_fl1:     state_d.result = {26'h0, find_last(i_first_source)};
                op_clb:     state_d.result = {26'h0, leading_bits(i_first_source)};
                op_cnt:     state_d.result = {26'h0, ones_count(i_first_source)};
                default:    state_d.result = `BMU_RST_RESULT;
            endcase
        end
    end

    // One register stage; results appear the cycle after the request
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_q <= '{valid: 1'b0, illegal: 1'b0, op: op_none, pos: 5'h00,
                         width_m1: 5'h00, result: `BMU_RST_RESULT};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state register
    assign o_valid   = state_q.valid;
    assign o_illegal = state_q.illegal;
    assign o_result  = state_q.result;

    // Checks on the registered results
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    property p_popcount;
        o_valid && !o_illegal && state_q.op == op_cnt |-> o_result == 32'($countones($past(i_first_source)));
    endproperty
    a_popcount: assert property (p_popcount) else $error("popcount wrong");

    property p_ff1_zero;
        o_valid && state_q.op == op_ff1 && $past(i_first_source) == 32'h0 |-> o_result == 32'h0000_0020;
    endproperty
    a_ff1_zero: assert property (p_ff1_zero) else $error("find first on zero not 32");

    property p_ff1;
        o_valid && state_q.op == op_ff1 && $past(i_first_source) != 32'h0 |->
            ((($past(i_first_source) >> o_result[4:0]) & 32'h1) == 32'h1)
            && (($past(i_first_source) << (6'h20 - o_result[5:0])) == 32'h0);
    endproperty
    a_ff1: assert property (p_ff1) else $error("find first index wrong");

    property p_fl1;
        o_valid && state_q.op == op_fl1 && $past(i_first_source) != 32'h0 |->
            ((($past(i_first_source) >> o_result[4:0]) & 32'h1) == 32'h1)
            && (($past(i_first_source) >> o_result[4:0]) == 32'h1);
    endproperty
    a_fl1: assert property (p_fl1) else $error("find last index wrong");

    property p_rotate;
        o_valid && state_q.op == op_rotate |->
            ((o_result << $past(i_second_source[4:0])) | (o_result >> (6'h20 - $past(i_second_source[4:0]))))
            == $past(i_first_source);
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate wrong");

    property p_clear;
        o_valid && state_q.op == op_clear |->
            ((o_result & ~$past(i_first_source)) == 32'h0) && !o_result[state_q.pos];
    endproperty
    a_clear: assert property (p_clear) else $error("clear sets bits or misses position");

    property p_set;
        o_valid && state_q.op == op_set |->
            ((~o_result & $past(i_first_source)) == 32'h0) && o_result[state_q.pos];
    endproperty
    a_set: assert property (p_set) else $error("set clears bits or misses position");

    property p_ext_u;
        o_valid && state_q.op == op_ext_u |->
            ({31'h0, o_result[0]} == (($past(i_first_source) >> state_q.pos) & 32'h1))
            && ((o_result >> (state_q.width_m1 + 6'h01)) == 32'h0);
    endproperty
    a_ext_u: assert property (p_ext_u) else $error("unsigned extract wrong");

    property p_disabled;
        !CUSTOM_EXTENSION_ENABLE && o_valid |-> o_illegal && o_result == 32'h0;
    endproperty
    a_disabled: assert property (p_disabled) else $error("op ran with extension off");

    property p_valid_follows;
        i_valid |=> o_valid;
    endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("valid not returned next cycle");

    c_ff1_zero: cover property (o_valid && state_q.op == op_ff1 && o_result == 32'h0000_0020);
    c_rev_grp3: cover property (o_valid && state_q.op == op_reverse && $past(i_instr[26:25]) == 2'h3);
    c_insert:   cover property (o_valid && state_q.op == op_insert);
    c_illegal:  cover property (o_valid && o_illegal);

endmodule : bit_manipulation_unit

// >>> hdl/bit_manipulation_unit_defs.svh
`ifndef BIT_MANIPULATION_UNIT_DEFS_SVH
`define BIT_MANIPULATION_UNIT_DEFS_SVH

// Major opcodes of the immediate and register groups
`define BMU_OPC_IMM          7'h5B
`define BMU_OPC_REG          7'h2B

// Minor opcodes (funct3)
`define BMU_F3_IMM_FIELD     3'h0
`define BMU_F3_IMM_BITS      3'h1
`define BMU_F3_REG           3'h3

// Immediate selector in bits 31:30
`define BMU_F2_A             2'h0
`define BMU_F2_B             2'h1
`define BMU_F2_C             2'h2
`define BMU_F2_D             2'h3

// Register-form funct7 codes
`define BMU_F7_EXT_S         7'h18
`define BMU_F7_EXT_U         7'h19
`define BMU_F7_INSERT        7'h1A
`define BMU_F7_CLEAR         7'h1C
`define BMU_F7_SET           7'h1D
`define BMU_F7_ROTATE        7'h20
`define BMU_F7_FF1           7'h21
`define BMU_F7_FL1           7'h22
`define BMU_F7_CLB           7'h23
`define BMU_F7_CNT           7'h24

// Instruction field positions
`define BMU_OPC_MSB          6
`define BMU_F3_MSB           14
`define BMU_F3_LSB           12
`define BMU_F2_MSB           31
`define BMU_F2_LSB           30
`define BMU_F7_MSB           31
`define BMU_F7_LSB           25
`define BMU_IMM_W_MSB        29
`define BMU_IMM_W_LSB        25
`define BMU_IMM_P_MSB        24
`define BMU_IMM_P_LSB        20
`define BMU_REV_PAD_MSB      29
`define BMU_REV_PAD_LSB      27
`define BMU_REV_GRP_MSB      26
`define BMU_REV_GRP_LSB      25

// Second-source field positions for register forms
`define BMU_RS_W_MSB         9
`define BMU_RS_W_LSB         5
`define BMU_RS_P_MSB         4
`define BMU_RS_P_LSB         0

// Fixed values
`define BMU_TOP_BIT          6'h1F
`define BMU_FIND_NONE        6'h20
`define BMU_RST_RESULT       32'h0000_0000

`endif

// >>> hdl/bm_decode_if.sv
`timescale 1ns/10ps
// Decoder to datapath bundle
interface bm_decode_if;
    import bit_manipulation_pkg::*;
    logic [31:0] instr;      // Instruction word
    op_t         op;         // Selected operation
    logic        reg_form;   // Position and width come from second source
    logic        illegal;    // Not one of ours, or extension off
    logic [4:0]  imm_w;      // Immediate width minus one
    logic [4:0]  imm_pos;    // Immediate position
    logic [1:0]  group;      // Reverse group selector

    modport dec (input instr, output op, reg_form, illegal, imm_w, imm_pos, group);
    modport alu (output instr, input op, reg_form, illegal, imm_w, imm_pos, group);
endinterface : bm_decode_if

// >>> hdl/bm_decoder.sv
`timescale 1ns/10ps
`include "bit_manipulation_unit_defs.svh"
module bm_decoder #(
    parameter bit CUSTOM_EXTENSION_ENABLE = 1'b1
) (
    bm_decode_if.dec d
);
    import bit_manipulation_pkg::*;

    // Pure decode, no state
    always_comb
    begin
        logic [6:0] opc;
        logic [2:0] f3;
        logic [1:0] f2;
        logic [6:0] f7;
        logic       rs2_zero;
        opc      = d.instr[`BMU_OPC_MSB:0];
        f3       = d.instr[`BMU_F3_MSB:`BMU_F3_LSB];
        f2       = d.instr[`BMU_F2_MSB:`BMU_F2_LSB];
        f7       = d.instr[`BMU_F7_MSB:`BMU_F7_LSB];
        rs2_zero = (d.instr[`BMU_IMM_P_MSB:`BMU_IMM_P_LSB] == 5'h00);
        d.op       = op_none;
        d.reg_form = 1'b0;
        d.imm_w    = d.instr[`BMU_IMM_W_MSB:`BMU_IMM_W_LSB];
        d.imm_pos  = d.instr[`BMU_IMM_P_MSB:`BMU_IMM_P_LSB];
        d.group    = d.instr[`BMU_REV_GRP_MSB:`BMU_REV_GRP_LSB];
        // Immediate field group
        if (opc == `BMU_OPC_IMM && f3 == `BMU_F3_IMM_FIELD)
        begin
            case (f2)
                `BMU_F2_A: d.op = op_ext_s;
                `BMU_F2_B: d.op = op_ext_u;
                `BMU_F2_C: d.op = op_insert;
                default:   d.op = op_none;
            endcase
        end
        // Immediate bit group; reverse needs its pad bits at zero
        else if (opc == `BMU_OPC_IMM && f3 == `BMU_F3_IMM_BITS)
        begin
            case (f2)
                `BMU_F2_A: d.op = op_clear;
                `BMU_F2_B: d.op = op_set;
                `BMU_F2_D: d.op = (d.instr[`BMU_REV_PAD_MSB:`BMU_REV_PAD_LSB] == 3'h0) ? op_reverse : op_none;
                default:   d.op = op_none;
            endcase
        end
        // Register group; unary forms demand a zero second-source field
        else if (opc == `BMU_OPC_REG && f3 == `BMU_F3_REG)
        begin
            d.reg_form = 1'b1;
            case (f7)
                `BMU_F7_EXT_S:  d.op = op_ext_s;
                `BMU_F7_EXT_U:  d.op = op_ext_u;
                `BMU_F7_INSERT: d.op = op_insert;
                `BMU_F7_CLEAR:  d.op = op_clear;
                `BMU_F7_SET:    d.op = op_set;
                `BMU_F7_ROTATE: d.op = op_rotate;
                `BMU_F7_FF1:    d.op = rs2_zero ? op_ff1 : op_none;
                `BMU_F7_FL1:    d.op = rs2_zero ? op_fl1 : op_none;
                `BMU_F7_CLB:    d.op = rs2_zero ? op_clb : op_none;
                `BMU_F7_CNT:    d.op = rs2_zero ? op_cnt : op_none;
                default:        d.op = op_none;
            endcase
        end
        // Whole group vanishes when the extension is not built in
        if (!CUSTOM_EXTENSION_ENABLE)
        begin
            d.op = op_none;
        end
        d.illegal = (d.op == op_none);
    end
endmodule : bm_decoder

// >>> test/bit_manipulation_unit_tb.sv
`timescale 1ns/10ps
// Self-checking bench: table of ordinary cases, then pipeline and reset cases
module bit_manipulation_unit_tb;
    typedef struct {
        logic [31:0] ins;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] d;
        logic [31:0] exp;
        logic        ill;
    } row_t;

    logic        clk;           // Core clock
    logic        sys_rst;       // Async reset, active high
    logic        valid;         // Request strobe from the model
    logic [31:0] instr;         // Instruction word
    logic [31:0] src_a;         // First source
    logic [31:0] src_b;         // Second source
    logic [31:0] dest_old;      // Old destination value
    logic        res_valid;     // Answer strobe
    logic        res_illegal;   // Refusal flag
    logic [31:0] result;        // Answer value
    logic        ill_off;       // Refusal flag, extension built out
    logic        valid_off;     // Answer strobe, extension built out
    logic [31:0] res_off;       // Answer, extension built out
    row_t        rows[$];       // Ordinary cases
    int          n_mismatch;
    int          num_checks;
    int          cycle_count;

    bm_issue_model u_bm_issue_model (
        .i_clk(clk), .o_valid(valid), .o_instr(instr), .o_first_source(src_a),
        .o_second_source(src_b), .o_dest_old(dest_old));

    bit_manipulation_unit #(.CUSTOM_EXTENSION_ENABLE(1'b1)) u_bit_manipulation_unit (
        .i_clk(clk), .i_sys_rst(sys_rst), .i_valid(valid), .i_instr(instr), .i_first_source(src_a),
        .i_second_source(src_b), .i_dest_old(dest_old), .o_valid(res_valid), .o_illegal(res_illegal),
        .o_result(result));

    // Second copy with the extension left out; it must refuse everything
    bit_manipulation_unit #(.CUSTOM_EXTENSION_ENABLE(1'b0)) u_bit_manipulation_unit_off (
        .i_clk(clk), .i_sys_rst(sys_rst), .i_valid(valid), .i_instr(instr), .i_first_source(src_a),
        .i_second_source(src_b), .i_dest_old(dest_old), .o_valid(valid_off), .o_illegal(ill_off),
        .o_result(res_off));

    // Clock at 100 MHz
    initial
    begin
        clk = 1'b0;
    end
    always #5 clk = ~clk;

    // Hang guard; the whole run needs about 120 cycles
    always @(posedge clk)
    begin
        cycle_count++;
        if (cycle_count >= 3000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    // Immediate-group encoding with source 1 and destination 2
    function automatic logic [31:0] ei(input logic [1:0] f2, input logic [2:0] f3, input logic [4:0] w,
                                       input logic [4:0] p);
        return {f2, w, p, 5'h01, f3, 5'h02, 7'h5B};
    endfunction : ei

    // Register-group encoding
    function automatic logic [31:0] er(input logic [6:0] f7, input logic [4:0] r2);
        return {f7, r2, 5'h01, 3'h3, 5'h02, 7'h2B};
    endfunction : er

    // Compare one value and count it
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic add(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] d, input logic [31:0] exp);
        rows.push_back('{ins, a, b, d, exp, 1'b0});
    endtask : add

    // Refused encodings: all-ones operand proves the result is forced to zero
    task automatic addx(input logic [31:0] ins);
        rows.push_back('{ins, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 1'b1});
    endtask : addx

    // Single verdict point
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    // Main sequence
    initial
    begin
        n_mismatch = 0;
        num_checks = 0;
        cycle_count = 0;
        sys_rst = 1'b1;
        add(ei(2'h0, 3'h0, 5'h3, 5'h4), 32'hA0, 32'h0, 32'h0, 32'hFFFFFFFA);
        add(ei(2'h1, 3'h0, 5'h3, 5'h4), 32'hA0, 32'h0, 32'h0, 32'hA);
        add(ei(2'h0, 3'h0, 5'h7, 5'h1C), 32'h80000000, 32'h0, 32'h0, 32'hFFFFFFF8);
        add(ei(2'h1, 3'h0, 5'h7, 5'h1C), 32'h80000000, 32'h0, 32'h0, 32'h8);
        add(ei(2'h2, 3'h0, 5'h7, 5'h8), 32'hAB, 32'h0, 32'h12345678, 32'h1234AB78);
        add(ei(2'h2, 3'h0, 5'h0, 5'h1F), 32'hFFFFFFFF, 32'h0, 32'h0, 32'h80000000);
        add(ei(2'h0, 3'h1, 5'h3, 5'h0), 32'hFFFFFFFF, 32'h0, 32'h0, 32'hFFFFFFF0);
        add(ei(2'h0, 3'h1, 5'h1F, 5'h10), 32'hFFFFFFFF, 32'h0, 32'h0, 32'hFFFF);
        add(ei(2'h1, 3'h1, 5'h3, 5'h1C), 32'h0, 32'h0, 32'h0, 32'hF0000000);
        add(ei(2'h1, 3'h1, 5'h1F, 5'h1F), 32'h0, 32'h0, 32'h0, 32'h80000000);
        add(ei(2'h3, 3'h1, 5'h0, 5'h0), 32'h1, 32'h0, 32'h0, 32'h80000000);
        add(ei(2'h3, 3'h1, 5'h3, 5'h0), 32'h1, 32'h0, 32'h0, 32'h80000000);
        add(ei(2'h3, 3'h1, 5'h1, 5'h0), 32'h1, 32'h0, 32'h0, 32'h40000000);
        add(ei(2'h3, 3'h1, 5'h2, 5'h0), 32'h40000000, 32'h0, 32'h0, 32'h2);
        add(ei(2'h3, 3'h1, 5'h2, 5'h4), 32'hC64A5933, 32'h0, 32'h0, 32'h216B244B);
        add(ei(2'h3, 3'h1, 5'h0, 5'h4), 32'hF, 32'h0, 32'h0, 32'h0F000000);
        add(er(7'h18, 5'h0), 32'hF00, 32'h68, 32'h0, 32'hFFFFFFFF);
        add(er(7'h19, 5'h0), 32'hF00, 32'h68, 32'h0, 32'hF);
        add(er(7'h18, 5'h0), 32'h80000000, 32'hBC, 32'h0, 32'hFFFFFFF8);
        add(er(7'h1A, 5'h0), 32'h5, 32'h5D, 32'h0, 32'hA0000000);
        add(er(7'h1A, 5'h0), 32'h3, 32'h20, 32'hFFFF0000, 32'hFFFF0003);
        add(er(7'h1C, 5'h0), 32'hFFFFFFFF, 32'h1F, 32'h0, 32'h7FFFFFFF);
        add(er(7'h1D, 5'h0), 32'h0, 32'h3E0, 32'h0, 32'hFFFFFFFF);
        add(er(7'h1D, 5'h0), 32'h0, 32'h7E, 32'h0, 32'hC0000000);
        add(er(7'h20, 5'h0), 32'h1, 32'hFFFFFFE1, 32'h0, 32'h80000000);
        add(er(7'h20, 5'h0), 32'h12345678, 32'h20, 32'h0, 32'h12345678);
        add(er(7'h20, 5'h0), 32'hF1, 32'h4, 32'h0, 32'h1000000F);
        add(er(7'h21, 5'h0), 32'h00010100, 32'h0, 32'h0, 32'h8);
        add(er(7'h21, 5'h0), 32'h0, 32'h0, 32'h0, 32'h20);
        add(er(7'h22, 5'h0), 32'h00010100, 32'h0, 32'h0, 32'h10);
        add(er(7'h22, 5'h0), 32'h0, 32'h0, 32'h0, 32'h20);
        add(er(7'h22, 5'h0), 32'h1, 32'h0, 32'h0, 32'h0);
        add(er(7'h23, 5'h0), 32'hFFFF, 32'h0, 32'h0, 32'hF);
        add(er(7'h23, 5'h0), 32'hFFF00000, 32'h0, 32'h0, 32'hB);
        add(er(7'h23, 5'h0), 32'h0, 32'h0, 32'h0, 32'h0);
        add(er(7'h24, 5'h0), 32'hF0F00001, 32'h0, 32'h0, 32'h9);
        add(er(7'h24, 5'h0), 32'hFFFFFFFF, 32'h0, 32'h0, 32'h20);
        addx(er(7'h21, 5'h3));
        addx(er(7'h1B, 5'h0));
        addx(er(7'h25, 5'h0));
        addx(er(7'h18, 5'h0) ^ 32'h1000);
        addx(ei(2'h3, 3'h0, 5'h3, 5'h4));
        addx(ei(2'h0, 3'h2, 5'h3, 5'h4));
        addx(ei(2'h0, 3'h0, 5'h3, 5'h4) ^ 32'h1);
        addx(ei(2'h2, 3'h1, 5'h3, 5'h4));
        addx(ei(2'h3, 3'h1, 5'h8, 5'h0));
        repeat (20) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk("valid after reset", 32'h0, {31'h0, res_valid});
        chk("result after reset", 32'h0, result);
        // Table: one request, one answer a cycle later
        foreach (rows[i])
        begin
            u_bm_issue_model.issue(rows[i].ins, rows[i].a, rows[i].b, rows[i].d);
            u_bm_issue_model.quiet();
            chk("valid", 32'h1, {31'h0, res_valid});
            chk("illegal", {31'h0, rows[i].ill}, {31'h0, res_illegal});
            chk("result", rows[i].exp, result);
            chk("disabled valid", 32'h1, {31'h0, valid_off});
            chk("disabled illegal", 32'h1, {31'h0, ill_off});
            chk("disabled result", 32'h0, res_off);
        end
        // Back to back: the first two answers land while the next request is already up
        u_bm_issue_model.issue(er(7'h21, 5'h0), 32'h80000000, 32'h0, 32'h0);
        u_bm_issue_model.issue(er(7'h23, 5'h0), 32'h80000000, 32'h0, 32'h0);
        chk("first of three", 32'h1F, result);
        u_bm_issue_model.issue(er(7'h24, 5'h0), 32'h80000000, 32'h0, 32'h0);
        chk("second of three", 32'h0, result);
        u_bm_issue_model.quiet();
        chk("third of three", 32'h1, result);
        chk("third valid", 32'h1, {31'h0, res_valid});
        u_bm_issue_model.quiet();
        chk("valid drops", 32'h0, {31'h0, res_valid});
        chk("result holds", 32'h1, result);
        // Reset lands while a request is up; the request must vanish
        u_bm_issue_model.issue(er(7'h24, 5'h0), 32'hFFFFFFFF, 32'h0, 32'h0);
        #2;
        sys_rst = 1'b1;
        #1;
        chk("result in reset", 32'h0, result);
        u_bm_issue_model.quiet();
        chk("valid in reset", 32'h0, {31'h0, res_valid});
        sys_rst = 1'b0;
        u_bm_issue_model.issue(er(7'h24, 5'h0), 32'hF, 32'h0, 32'h0);
        u_bm_issue_model.quiet();
        chk("count after reset", 32'h4, result);
        chk("overflowing inserts", 32'h0, u_bm_issue_model.bad_inserts);
        close_out();
    end
endmodule : bit_manipulation_unit_tb

// >>> test/bm_issue_model.sv
`timescale 1ns/10ps
// Stand-in for the decode stage and register file feeding the unit
module bm_issue_model (
    input  wire logic        i_clk,
    output logic             o_valid,
    output logic [31:0]      o_instr,
    output logic [31:0]      o_first_source,
    output logic [31:0]      o_second_source,
    output logic [31:0]      o_dest_old
);
    int bad_inserts;    // Inserts issued with an overflowing field

    // Quiet bus at time zero
    initial
    begin
        bad_inserts = 0;
        o_valid = 1'b0;
        o_instr = 32'h0;
        o_first_source = 32'h0;
        o_second_source = 32'h0;
        o_dest_old = 32'h0;
    end

    // Present one request just after an edge; the unit takes it at the next edge
    task automatic issue(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                         input logic [31:0] d);
        @(posedge i_clk);
        #1;
        // Software never lets an insert run past bit 31; count any slip
        if (ins[6:0] == 7'h5B && ins[14:12] == 3'h0 && ins[31:30] == 2'h2
            && ({1'b0, ins[29:25]} + {1'b0, ins[24:20]}) > 6'h1F)
            bad_inserts++;
        if (ins[6:0] == 7'h2B && ins[31:25] == 7'h1A && ({1'b0, b[9:5]} + {1'b0, b[4:0]}) > 6'h1F)
            bad_inserts++;
        o_valid = 1'b1;
        o_instr = ins;
        o_first_source = a;
        o_second_source = b;
        o_dest_old = d;
    endtask : issue

    // Drop the request; operands flip so stale values never pass for live ones
    task automatic quiet();
        @(posedge i_clk);
        #1;
        o_valid = 1'b0;
        o_instr = ~o_instr;
        o_first_source = ~o_first_source;
        o_second_source = ~o_second_source;
        o_dest_old = ~o_dest_old;
    endtask : quiet
endmodule : bm_issue_model
